// ### design/campp_params.svh
// constants and register map of the camera pixel pipeline
`ifndef CAMPP_PARAMS_SVH
`define CAMPP_PARAMS_SVH

// frame geometry, table and list sizes
`define PP_IMG_W 1920
`define PP_IMG_H 1200
`define PP_PIX_W 12
`define PP_LUT_DEPTH 4096
`define PP_DEFECTS 2048

// register offsets
`define PP_REG_FORMAT 8'h00
`define PP_REG_HSKIP 8'h04
`define PP_REG_VSKIP 8'h08
`define PP_REG_MIRROR_H 8'h0C
`define PP_REG_MIRROR_V 8'h10
`define PP_REG_LUT_EN 8'h14
`define PP_REG_LUT_SEL 8'h18
`define PP_REG_LOOKUP_ENTRY_INDEX 8'h1C
`define PP_REG_LOOKUP_ENTRY_VALUE 8'h20
`define PP_REG_DEF_MASTER 8'h24
`define PP_REG_DEF_INDEX 8'h28
`define PP_REG_DEF_COL 8'h2C
`define PP_REG_DEF_ROW 8'h30
`define PP_REG_DEF_EN 8'h34
`define PP_REG_STATUS 8'h38

// field values and reset values
`define PP_FLAG_BIT 0
`define PP_FMT_MSB 3
`define PP_SKIP_OFF 32'h00000001
`define PP_SKIP_ON 32'h00000002
`define PP_LUT_SEL_LUMA 1'b0
`define PP_DEF_MASTER_RST 1'b1

`endif

// ### design/campp_pkg.sv
// types shared by the camera pixel pipeline
`include "campp_params.svh"
package campp_pkg;
	// output pixel formats, mono first, colour-only from bayer 8 on
	typedef enum logic [3:0] {
		FMT_MONO8, FMT_MONO10, FMT_MONO10P, FMT_MONO12, FMT_MONO12P,
		FMT_BAYER8, FMT_BAYER10, FMT_BAYER10P, FMT_BAYER12, FMT_BAYER12P,
		FMT_RGB8
	} campp_fmt_type;

	// capture and send sequence
	typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_SEND} campp_state_type;

	// one sensor pixel with its frame start mark
	typedef struct packed {
		logic sof;
		logic [`PP_PIX_W-1:0] pixel;
	} campp_in_type;

	// one output byte with frame marks
	typedef struct packed {
		logic sof;
		logic eof;
		logic [7:0] data;
	} campp_out_type;

	// frame-wide settings
	typedef struct packed {
		campp_fmt_type fmt;
		logic skip2;
		logic mirror_h;
		logic mirror_v;
		logic lut_en;
	} campp_cfg_type;
endpackage

// ### design/campp_pipeline.sv
// camera pixel pipeline: defect fix, lookup, frame store, flip, skip, pack
//
// The implementer's own choices: the address map and the strobed register port.
`include "campp_params.svh"
module campp_pipeline #(
	parameter int IMG_W = `PP_IMG_W,
	parameter int IMG_H = `PP_IMG_H,
	parameter int LUT_DEPTH = `PP_LUT_DEPTH,
	parameter int DEFECTS = `PP_DEFECTS,
	parameter bit COLOR = 1'b1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// sensor pixel stream
	input wire campp_pkg::campp_in_type in_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// packed byte stream
	output campp_pkg::campp_out_type out_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int PW = `PP_PIX_W;
	localparam int XW = $clog2(IMG_W);
	localparam int YW = $clog2(IMG_H);
	localparam int AW = $clog2(IMG_W * IMG_H);
	localparam int LW = $clog2(LUT_DEPTH);
	localparam int DW = $clog2(DEFECTS);
	localparam int DIST = COLOR ? 2 : 1;

	// settings as written and as frozen for the current frame
	campp_pkg::campp_cfg_type cfg_q, cfg_d, act_q, act_d;
	logic def_master_q, def_master_d;
	logic [LW-1:0] lut_idx_q, lut_idx_d;
	logic [DW-1:0] def_idx_q, def_idx_d;
	logic [31:0] rdata_q, rdata_d;

	// storage
	logic [PW-1:0] lut_q [LUT_DEPTH];
	logic [XW-1:0] def_col_q [DEFECTS];
	logic [YW-1:0] def_row_q [DEFECTS];
	logic def_en_q [DEFECTS];
	logic [PW-1:0] frame_q [IMG_W * IMG_H];

	// sequence state
	campp_pkg::campp_state_type state_q, state_d;
	logic [XW-1:0] col_q, col_d, ox_q, ox_d;
	logic [YW-1:0] row_q, row_d, oy_q, oy_d;
	logic [1:0] bi_q, bi_d;
	logic [PW-1:0] p1_q, p1_d, p2_q, p2_d;
	campp_pkg::campp_out_type ob_q, ob_d;
	logic ov_q, ov_d;

	// capture path signals
	logic start, take, hit, fix, lut_on;
	logic [XW-1:0] cur_col;
	logic [YW-1:0] cur_row;
	logic [PW-1:0] fixed_pix, wr_pix;
	logic [AW-1:0] wr_addr;

	// send path signals
	int ow, oh, sx0, sx1, sy, cx, cy;
	logic pair_ok, two, load;
	logic [1:0] nb;
	logic [PW-1:0] q0, q1, q2;
	logic [23:0] gw;

	// source coordinate of an output position, with skip and mirror
	function automatic int srcpos(int o, logic mir, logic sk, int full);
		int s;
		s = sk ? 2 * o : o;
		return mir ? full - 1 - s : s;
	endfunction

	// one stored pixel by column and row
	function automatic logic [PW-1:0] pix(int x, int y);
		return frame_q[AW'(y * IMG_W + x)];
	endfunction

	// register writes and read data
	always_comb begin
		cfg_d = cfg_q;
		def_master_d = def_master_q;
		lut_idx_d = lut_idx_q;
		def_idx_d = def_idx_q;
		rdata_d = '0;
		if (reg_we_i) begin
			case (reg_addr_i)
				`PP_REG_FORMAT: begin
					// colour formats only on colour units
					if (reg_wdata_i[`PP_FMT_MSB:0] <= campp_pkg::FMT_RGB8 &&
						(COLOR || reg_wdata_i[`PP_FMT_MSB:0] < campp_pkg::FMT_BAYER8)) begin
						cfg_d.fmt = campp_pkg::campp_fmt_type'(reg_wdata_i[`PP_FMT_MSB:0]);
					end
				end
				`PP_REG_HSKIP, `PP_REG_VSKIP: begin
					// one skip bit serves both directions
					if (reg_wdata_i == `PP_SKIP_OFF) begin
						cfg_d.skip2 = 1'b0;
					end else if (reg_wdata_i == `PP_SKIP_ON) begin
						cfg_d.skip2 = 1'b1;
					end
				end
				`PP_REG_MIRROR_H: cfg_d.mirror_h = reg_wdata_i[`PP_FLAG_BIT];
				`PP_REG_MIRROR_V: cfg_d.mirror_v = reg_wdata_i[`PP_FLAG_BIT];
				`PP_REG_LUT_EN: cfg_d.lut_en = reg_wdata_i[`PP_FLAG_BIT];
				`PP_REG_LOOKUP_ENTRY_INDEX: lut_idx_d = reg_wdata_i[LW-1:0];
				`PP_REG_DEF_MASTER: def_master_d = reg_wdata_i[`PP_FLAG_BIT];
				`PP_REG_DEF_INDEX: def_idx_d = reg_wdata_i[DW-1:0];
				default: ;
			endcase
		end
		if (reg_re_i) begin
			case (reg_addr_i)
				`PP_REG_FORMAT: rdata_d[`PP_FMT_MSB:0] = cfg_q.fmt;
				`PP_REG_HSKIP, `PP_REG_VSKIP: rdata_d = cfg_q.skip2 ? `PP_SKIP_ON : `PP_SKIP_OFF;
				`PP_REG_MIRROR_H: rdata_d[`PP_FLAG_BIT] = cfg_q.mirror_h;
				`PP_REG_MIRROR_V: rdata_d[`PP_FLAG_BIT] = cfg_q.mirror_v;
				`PP_REG_LUT_EN: rdata_d[`PP_FLAG_BIT] = cfg_q.lut_en;
				`PP_REG_LUT_SEL: rdata_d[`PP_FLAG_BIT] = `PP_LUT_SEL_LUMA;
				`PP_REG_LOOKUP_ENTRY_INDEX: rdata_d[LW-1:0] = lut_idx_q;
				`PP_REG_LOOKUP_ENTRY_VALUE: rdata_d[PW-1:0] = lut_q[lut_idx_q];
				`PP_REG_DEF_MASTER: rdata_d[`PP_FLAG_BIT] = def_master_q;
				`PP_REG_DEF_INDEX: rdata_d[DW-1:0] = def_idx_q;
				`PP_REG_DEF_COL: rdata_d[XW-1:0] = def_col_q[def_idx_q];
				`PP_REG_DEF_ROW: rdata_d[YW-1:0] = def_row_q[def_idx_q];
				`PP_REG_DEF_EN: rdata_d[`PP_FLAG_BIT] = def_en_q[def_idx_q];
				`PP_REG_STATUS: rdata_d[1:0] = state_q;
				default: rdata_d = '0;
			endcase
		end
	end

	// register bank flops
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_q <= '0;
			def_master_q <= `PP_DEF_MASTER_RST;
			lut_idx_q <= '0;
			def_idx_q <= '0;
			rdata_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			def_master_q <= def_master_d;
			lut_idx_q <= lut_idx_d;
			def_idx_q <= def_idx_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// table entry written at the held index
	always_ff @(posedge clock_i) begin
		if (reg_we_i && reg_addr_i == `PP_REG_LOOKUP_ENTRY_VALUE) begin
			lut_q[lut_idx_q] <= reg_wdata_i[PW-1:0];
		end
	end

	// defect list entries through the held index
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < DEFECTS; i++) begin
				def_col_q[i] <= '0;
				def_row_q[i] <= '0;
				def_en_q[i] <= 1'b0;
			end
		end else if (reg_we_i) begin
			if (reg_addr_i == `PP_REG_DEF_COL) begin
				def_col_q[def_idx_q] <= reg_wdata_i[XW-1:0];
			end
			if (reg_addr_i == `PP_REG_DEF_ROW) begin
				def_row_q[def_idx_q] <= reg_wdata_i[YW-1:0];
			end
			if (reg_addr_i == `PP_REG_DEF_EN) begin
				def_en_q[def_idx_q] <= reg_wdata_i[`PP_FLAG_BIT];
			end
		end
	end

	// capture: position, defect search, correction and lookup
	always_comb begin
		start = in_valid_i && in_ready_o && in_i.sof;
		take = in_valid_i && in_ready_o && (in_i.sof || state_q == campp_pkg::ST_FILL);
		cur_col = start ? '0 : col_q;
		cur_row = start ? '0 : row_q;
		hit = 1'b0;
		for (int i = 0; i < DEFECTS; i++) begin
			if (def_en_q[i] && def_col_q[i] == cur_col && def_row_q[i] == cur_row) begin
				hit = 1'b1;
			end
		end
		fix = def_master_q && hit && int'(cur_col) >= DIST;
		fixed_pix = fix ? (COLOR ? p2_q : p1_q) : in_i.pixel;
		lut_on = start ? cfg_q.lut_en : act_q.lut_en;
		wr_pix = lut_on ? lut_q[fixed_pix[LW-1:0]] : fixed_pix;
		wr_addr = AW'(int'(cur_row) * IMG_W + int'(cur_col));
	end

	// frame store write
	always_ff @(posedge clock_i) begin
		if (take) begin
			frame_q[wr_addr] <= wr_pix;
		end
	end

	// send: source positions for the current output group
	always_comb begin
		two = 1'b0;
		nb = 2'd1;
		ow = act_q.skip2 ? IMG_W / 2 : IMG_W;
		oh = act_q.skip2 ? IMG_H / 2 : IMG_H;
		pair_ok = int'(ox_q) + 1 < ow;
		sx0 = srcpos(int'(ox_q), act_q.mirror_h, act_q.skip2, IMG_W);
		sx1 = pair_ok ? srcpos(int'(ox_q) + 1, act_q.mirror_h, act_q.skip2, IMG_W) : sx0;
		sy = srcpos(int'(oy_q), act_q.mirror_v, act_q.skip2, IMG_H);
		cx = sx0 - sx0 % 2;
		cy = sy - sy % 2;
		q0 = pix(sx0, sy);
		q1 = pair_ok ? pix(sx1, sy) : '0;
		q2 = '0;
		if (act_q.fmt == campp_pkg::FMT_RGB8) begin
			// red, green and blue of the enclosing rg cell
			q0 = pix(cx, cy);
			q1 = pix(cx + 1, cy);
			q2 = pix(cx + 1, cy + 1);
		end
		// byte layout of one group, first byte lowest
		case (act_q.fmt)
			campp_pkg::FMT_MONO10, campp_pkg::FMT_BAYER10: begin
				gw = {14'h0000, q0[11:2]};
				nb = 2'd2;
			end
			campp_pkg::FMT_MONO10P, campp_pkg::FMT_BAYER10P: begin
				gw = {q1[11:4], 2'h0, q1[3:2], 2'h0, q0[3:2], q0[11:4]};
				nb = 2'd3;
				two = 1'b1;
			end
			campp_pkg::FMT_MONO12, campp_pkg::FMT_BAYER12: begin
				gw = {12'h000, q0};
				nb = 2'd2;
			end
			campp_pkg::FMT_MONO12P, campp_pkg::FMT_BAYER12P: begin
				gw = {q1[11:4], q1[3:0], q0[3:0], q0[11:4]};
				nb = 2'd3;
				two = 1'b1;
			end
			campp_pkg::FMT_RGB8: begin
				gw = {q2[11:4], q1[11:4], q0[11:4]};
				nb = 2'd3;
			end
			default: gw = {16'h0000, q0[11:4]};
		endcase
	end

	// sequence: capture a frame, then send it byte by byte
	always_comb begin
		state_d = state_q;
		act_d = act_q;
		col_d = col_q;
		row_d = row_q;
		p1_d = p1_q;
		p2_d = p2_q;
		ox_d = ox_q;
		oy_d = oy_q;
		bi_d = bi_q;
		ob_d = ob_q;
		ov_d = ov_q;
		load = !ov_q || out_ready_i;
		if (take) begin
			p1_d = in_i.pixel;
			p2_d = p1_q;
			if (start) begin
				act_d = cfg_q;
			end
			if (int'(cur_col) == IMG_W - 1) begin
				col_d = '0;
				if (int'(cur_row) == IMG_H - 1) begin
					row_d = '0;
					state_d = campp_pkg::ST_SEND;
				end else begin
					row_d = cur_row + YW'(1);
					state_d = campp_pkg::ST_FILL;
				end
			end else begin
				col_d = cur_col + XW'(1);
				row_d = cur_row;
				state_d = campp_pkg::ST_FILL;
			end
		end
		if (state_q == campp_pkg::ST_SEND && load) begin
			ov_d = 1'b1;
			ob_d.data = gw[8 * bi_q +: 8];
			ob_d.sof = ox_q == '0 && oy_q == '0 && bi_q == 2'd0;
			ob_d.eof = 1'b0;
			if (bi_q == nb - 2'd1) begin
				bi_d = 2'd0;
				if (int'(ox_q) + (two ? 2 : 1) >= ow) begin
					ox_d = '0;
					if (int'(oy_q) == oh - 1) begin
						oy_d = '0;
						ob_d.eof = 1'b1;
						state_d = campp_pkg::ST_IDLE;
					end else begin
						oy_d = oy_q + YW'(1);
					end
				end else begin
					ox_d = ox_q + (two ? XW'(2) : XW'(1));
				end
			end else begin
				bi_d = bi_q + 2'd1;
			end
		end else if (load) begin
			ov_d = 1'b0;
		end
	end

	// sequence flops
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= campp_pkg::ST_IDLE;
			act_q <= '0;
			col_q <= '0;
			row_q <= '0;
			p1_q <= '0;
			p2_q <= '0;
			ox_q <= '0;
			oy_q <= '0;
			bi_q <= 2'd0;
			ob_q <= '0;
			ov_q <= 1'b0;
		end else begin
			state_q <= state_d;
			act_q <= act_d;
			col_q <= col_d;
			row_q <= row_d;
			p1_q <= p1_d;
			p2_q <= p2_d;
			ox_q <= ox_d;
			oy_q <= oy_d;
			bi_q <= bi_d;
			ob_q <= ob_d;
			ov_q <= ov_d;
		end
	end

	// stream handshakes
	assign in_ready_o = state_q != campp_pkg::ST_SEND;
	assign out_o = ob_q;
	assign out_valid_o = ov_q;

	// checks
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	chk_fmt_refused: assert property (
		reg_we_i && reg_addr_i == `PP_REG_FORMAT &&
		(reg_wdata_i[`PP_FMT_MSB:0] > campp_pkg::FMT_RGB8 ||
		!COLOR && reg_wdata_i[`PP_FMT_MSB:0] >= campp_pkg::FMT_BAYER8) |=> $stable(cfg_q.fmt))
		else $error("unit took a format it does not offer");
	chk_mono12_high: assert property (
		state_q == campp_pkg::ST_SEND && load && act_q.fmt == campp_pkg::FMT_MONO12 &&
		bi_q == 2'd1 |=> ob_q.data[7:4] == 4'h0)
		else $error("unpacked 12-bit high byte not zero padded");
	chk_hskip_both: assert property (
		reg_we_i && reg_addr_i == `PP_REG_HSKIP && reg_wdata_i == `PP_SKIP_ON |=> cfg_q.skip2)
		else $error("horizontal skip not applied");
	chk_vskip_off: assert property (
		reg_we_i && reg_addr_i == `PP_REG_VSKIP && reg_wdata_i == `PP_SKIP_OFF |=> !cfg_q.skip2)
		else $error("vertical skip off not applied");
	chk_mirror_x: assert property (
		state_q == campp_pkg::ST_SEND && act_q.mirror_h && ox_q == '0 |-> sx0 == IMG_W - 1)
		else $error("mirrored line does not start at last column");
	chk_plain_y: assert property (
		state_q == campp_pkg::ST_SEND && !act_q.mirror_v && oy_q == '0 |-> sy == 0)
		else $error("unmirrored frame does not start at first line");
	chk_lut_select: assert property (
		reg_re_i && reg_addr_i == `PP_REG_LUT_SEL |=> reg_rdata_o == 32'h00000000)
		else $error("table select not luminance");
	chk_lut_bypass: assert property (
		take && !lut_on && !fix |-> wr_pix == in_i.pixel)
		else $error("pixel altered with table off");
	chk_master_off: assert property (
		!def_master_q |-> !fix)
		else $error("correction with master switch off");
	chk_cfg_frozen: assert property (
		take && !start |=> $stable(act_q))
		else $error("settings changed inside a frame");
endmodule

// ### dv/campp_far_model.sv
// sensor source and byte sink that face the pixel pipeline
module campp_far_model #(
	parameter int W = 4,
	parameter int H = 2
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// control from the bench
	input wire logic start_i,
	input wire logic stall_i,
	// pipeline side
	output campp_pkg::campp_in_type in_o,
	output logic in_valid_o,
	input wire logic in_ready_i,
	input wire campp_pkg::campp_out_type out_i,
	input wire logic out_valid_i,
	output logic out_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	campp_pkg::campp_out_type got [$];
	int n;
	logic tog;

	// sensor level of a pixel, distinct for every position
	function automatic logic [11:0] pix(input int r, input int c);
		return 12'(12'h3A5 + r * 12'h1C3 + c * 12'h057);
	endfunction

	// raster source: holds each pixel until taken, drives the inverse when idle
	initial begin
		in_valid_o = 1'b0;
		in_o = '0;
		forever begin
			@(posedge clock_i);
			if (start_i) begin
				for (n = 0; n < W * H; n++) begin // same pace with or without decimation
					in_valid_o <= 1'b1;
					in_o <= {n == 0, pix(n / W, n % W)};
					do @(posedge clock_i); while (!in_ready_i);
				end
				in_valid_o <= 1'b0;
				in_o <= ~in_o;
			end
		end
	end

	// byte sink: takes every byte, or every other cycle while stalling
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
			if (out_valid_i && out_ready_o) got.push_back(out_i);
		end
	end
	assign out_ready_o = !stall_i || tog;
endmodule

// ### dv/testbench.sv
// self-checking bench for the camera pixel pipeline
`include "campp_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 4;
	localparam int H = 2;
	logic clock_i;
	logic rstn_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_we_i;
	logic reg_re_i;
	logic [31:0] reg_rdata_o;
	campp_pkg::campp_in_type in_i;
	logic in_valid_i;
	logic in_ready_o;
	campp_pkg::campp_out_type out_o;
	logic out_valid_o;
	logic out_ready_i;
	logic start;
	logic stall;
	int bad_count;
	int comparisons;
	int cycles;
	int i;
	logic [11:0] p;
	logic [8:0] exp_b [$];

	// design and far side
	campp_pipeline #(.IMG_W(W), .IMG_H(H), .DEFECTS(4)) campp_pipeline_i (
		.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .in_i(in_i), .in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o), .out_o(out_o), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i));
	campp_far_model #(.W(W), .H(H)) campp_far_model_i (
		.clock_i(clock_i), .rstn_i(rstn_i), .start_i(start), .stall_i(stall),
		.in_o(in_i), .in_valid_o(in_valid_i), .in_ready_i(in_ready_o),
		.out_i(out_o), .out_valid_i(out_valid_o), .out_ready_o(out_ready_i));

	// verdict and end of run
	task automatic end_of_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// register write and read, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_re_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask

	// expected level: defect taken from the same-colour left neighbour, then table
	function automatic logic [11:0] val(input int r, input int c, input int dr,
		input int dc, input bit lon);
		logic [11:0] v;
		v = campp_far_model_i.pix(r, (r == dr && c == dc && c >= 2) ? c - 2 : c);
		return lon ? ~v : v;
	endfunction
	function automatic void put(input logic [7:0] b);
		exp_b.push_back({1'b1, b});
	endfunction

	// configure, send one frame and compare every byte
	task automatic frame(input int f, input bit mh, input bit mv, input bit sk,
		input bit lon, input int dr, input int dc);
		logic [11:0] q [$];
		int sr [$];
		int sc [$];
		int r;
		int c;
		int k;
		campp_pkg::campp_out_type g;
		exp_b = {};
		for (r = 0; r < H; r += sk ? 2 : 1) begin
			for (c = 0; c < W; c += sk ? 2 : 1) begin
				sr.push_back(mv ? H - 1 - r : r);
				sc.push_back(mh ? W - 1 - c : c);
				q.push_back(val(sr[$], sc[$], dr, dc, lon));
			end
		end
		for (k = 0; k < q.size(); k++) begin
			p = q[k];
			case (f)
				0, 5: put(p[11:4]);
				1, 6: begin put(p[9:2]); put({6'h0, p[11:10]}); end
				2, 7: if (k[0]) begin
					put(q[k-1][11:4]);
					put({2'h0, p[3:2], 2'h0, q[k-1][3:2]});
					put(p[11:4]);
				end
				3, 8: begin put(p[7:0]); put({4'h0, p[11:8]}); end
				4, 9: if (k[0]) begin
					put(q[k-1][11:4]);
					put({p[3:0], q[k-1][3:0]});
					put(p[11:4]);
				end
				default: begin
					p = campp_far_model_i.pix(sr[k] & ~1, sc[k] & ~1);
					put(p[11:4]);
					p = campp_far_model_i.pix(sr[k] & ~1, sc[k] | 1);
					put(p[11:4]);
					p = campp_far_model_i.pix(sr[k] | 1, sc[k] | 1);
					put(p[11:4]);
				end
			endcase
		end
		wr(`PP_REG_FORMAT, f);
		wr(`PP_REG_MIRROR_H, {31'h0, mh});
		wr(`PP_REG_MIRROR_V, {31'h0, mv});
		wr(`PP_REG_HSKIP, sk ? 32'h2 : 32'h1);
		wr(`PP_REG_LUT_EN, {31'h0, lon});
		@(posedge clock_i);
		stall <= f[0];
		start <= 1'b1;
		@(posedge clock_i);
		start <= 1'b0;
		for (k = 0; k < 2000 && campp_far_model_i.got.size() < exp_b.size(); k++)
			@(posedge clock_i);
		repeat (4) @(posedge clock_i);
		chk(campp_far_model_i.got.size(), exp_b.size());
		chk({31'h0, in_ready_o}, 32'h1);
		chk({30'h0, campp_far_model_i.got[0].sof, campp_far_model_i.got[$].eof}, 32'h3);
		for (k = 0; k < campp_far_model_i.got.size(); k++) begin
			g = campp_far_model_i.got[k];
			chk({g.sof, g.eof, g.data}, {k == 0, k == exp_b.size() - 1, exp_b[k][7:0]});
		end
		campp_far_model_i.got = {};
	endtask

	// clock
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// cycle ceiling against a hang
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			end_of_test;
		end
	end

	// main sequence
	initial begin
		rstn_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		start = 1'b0;
		stall = 1'b0;
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (16) @(posedge clock_i);
		rstn_i <= 1'b1;
		// reset values
		rd(`PP_REG_FORMAT, 32'h0);
		rd(`PP_REG_HSKIP, 32'h1);
		rd(`PP_REG_VSKIP, 32'h1);
		rd(`PP_REG_MIRROR_H, 32'h0);
		rd(`PP_REG_MIRROR_V, 32'h0);
		rd(`PP_REG_LUT_SEL, 32'h0);
		rd(`PP_REG_DEF_MASTER, 32'h1);
		rd(`PP_REG_DEF_INDEX, 32'h0);
		rd(`PP_REG_DEF_COL, 32'h0);
		rd(`PP_REG_DEF_ROW, 32'h0);
		rd(`PP_REG_DEF_EN, 32'h0);
		rd(`PP_REG_LUT_EN, 32'h0);
		rd(`PP_REG_STATUS, 32'h0);
		// refused writes, unmapped place and joint decimation
		wr(8'h3C, 32'h5);
		rd(8'h3C, 32'h0);
		wr(`PP_REG_FORMAT, 32'hB);
		rd(`PP_REG_FORMAT, 32'h0);
		wr(`PP_REG_VSKIP, 32'h2);
		rd(`PP_REG_HSKIP, 32'h2);
		wr(`PP_REG_HSKIP, 32'h3);
		rd(`PP_REG_VSKIP, 32'h2);
		wr(`PP_REG_VSKIP, 32'h1);
		rd(`PP_REG_HSKIP, 32'h1);
		wr(`PP_REG_LUT_SEL, 32'h1);
		rd(`PP_REG_LUT_SEL, 32'h0);
		// every format with mixed flips and decimation
		for (i = 0; i < 11; i++) frame(i, i[0], i[1], i[2], 0, -1, -1);
		// a mirror change in mid-frame waits for the next frame
		fork
			frame(3, 1, 0, 0, 0, -1, -1);
			begin
				repeat (15) @(posedge clock_i);
				wr(`PP_REG_MIRROR_H, 32'h0);
			end
		join
		// lookup table inverts every level in use
		for (i = 0; i < W * H; i++) begin
			p = ~campp_far_model_i.pix(i / W, i % W);
			wr(`PP_REG_LOOKUP_ENTRY_INDEX, {20'h0, campp_far_model_i.pix(i / W, i % W)});
			wr(`PP_REG_LOOKUP_ENTRY_VALUE, {20'h0, p});
		end
		rd(`PP_REG_LOOKUP_ENTRY_VALUE, {20'h0, p});
		rd(`PP_REG_LOOKUP_ENTRY_INDEX, {20'h0, ~p});
		frame(3, 0, 1, 0, 1, -1, -1);
		// defect list: entry 1 enabled, entry 0 left off
		wr(`PP_REG_DEF_INDEX, 32'h1);
		wr(`PP_REG_DEF_COL, 32'h2);
		wr(`PP_REG_DEF_ROW, 32'h1);
		wr(`PP_REG_DEF_EN, 32'h1);
		wr(`PP_REG_DEF_INDEX, 32'h0);
		wr(`PP_REG_DEF_COL, 32'h3);
		rd(`PP_REG_DEF_EN, 32'h0);
		wr(`PP_REG_DEF_INDEX, 32'h1);
		rd(`PP_REG_DEF_COL, 32'h2);
		rd(`PP_REG_DEF_ROW, 32'h1);
		frame(3, 0, 0, 0, 0, 1, 2);
		wr(`PP_REG_DEF_MASTER, 32'h0);
		frame(3, 0, 0, 0, 0, -1, -1);
		end_of_test;
	end
endmodule
